// File: rtl/hpp_host_port.sv
/*
 Host parallel slave port: byte mailbox (mode 0) and fast internal bus
 access (mode 1). Host strobes are asynchronous and are synchronised
 through three flops; a change counts when the second and third agree.
 Assumes the control CPU drains the inbound byte and the internal bus
 answers each request with an acknowledge.
*/
// Contract
// - Firmware can be downloaded by the host through this port at power-up.
// - Mode select low gives mailbox mode; register select picks data or status.
// - Mailbox mode moves bytes over an 8-bit bidirectional data bus.
// - Status byte is driven when mode low, select high, read and chip select low.
// - Status: bit 7 outbound vacant, bit 6 inbound full, bits 5-4 zero, tag low nibble.
// - Outbound vacant is always the inverse of the host attention output.
// - Host data read sets vacant; attention drops at the read strobe rising edge.
// - Host must not write while inbound full; clearing it signals readiness.
// - Inbound full holds while the CPU FIFO full bit is set.
// - Inbound full holds until the previous host byte reached the CPU FIFO.
// - Mode select high gives fast mode; register select is ignored.
// - Fast mode supports an 8-bit or 16-bit data bus.
// - Fast mode reads and writes internal bus targets, single or burst by firmware.
// - After each fast read strobe rise, ready goes low at least 15 ns.
// - After each fast write strobe rise, ready goes low at least 15 ns.
module hpp_host_port
    import hpp_pkg::*;
#(
    parameter int ADDR_W = 24
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic host_select_n,
    input wire logic port_mode_select_line,
    input wire logic register_select_line,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic [HPP_FAST_W-1:0] host_data_bus_in,
    output logic [HPP_FAST_W-1:0] host_data_bus_out,
    output logic host_data_bus_oe_n,
    output logic host_attention_out,
    output logic transfer_ready_out,
    input wire logic wide_bus_enable,
    input wire logic burst_enable,
    input wire logic [ADDR_W-1:0] burst_base_addr,
    input wire logic [HPP_TAG_W-1:0] stream_tag,
    input wire logic outbound_load,
    input wire logic [HPP_MBOX_W-1:0] outbound_byte,
    input wire logic cpu_fifo_full_bit,
    input wire logic cpu_take,
    output logic inbound_valid,
    output logic [HPP_MBOX_W-1:0] inbound_byte,
    output logic inbound_is_control,
    output logic abus_req,
    output logic abus_write,
    output logic [ADDR_W-1:0] abus_addr,
    output logic [HPP_FAST_W-1:0] abus_wdata,
    input wire logic abus_ack,
    input wire logic [HPP_FAST_W-1:0] abus_rdata
);
    logic [HPP_SYNC_W-1:0] cs_sync_reg, rd_sync_reg, wr_sync_reg, a1_sync_reg, a0_sync_reg;
    logic cs_reg, rd_reg, wr_reg, a1_reg, a0_reg;
    logic [HPP_MBOX_W-1:0] out_byte_reg;
    logic [HPP_FAST_W-1:0] read_word_reg;
    logic [HPP_FAST_W-1:0] wdata_reg;
    logic inbound_full_reg;
    logic rd_rise, wr_rise, sel_mbox, sel_fast;
    logic [7:0] ready_cnt_reg;
    hpp_fast_state_t fast_state_reg;
    logic fast_pending_reg, fast_is_write_reg;
    logic [HPP_MBOX_W-1:0] status_byte;

    // Three-flop synchronisers for host pins
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cs_sync_reg <= '1;
            rd_sync_reg <= '1;
            wr_sync_reg <= '1;
            a1_sync_reg <= '0;
            a0_sync_reg <= '0;
        end
        else
        begin
            cs_sync_reg <= {cs_sync_reg[1:0], host_select_n};
            rd_sync_reg <= {rd_sync_reg[1:0], host_read_strobe_n};
            wr_sync_reg <= {wr_sync_reg[1:0], host_write_strobe_n};
            a1_sync_reg <= {a1_sync_reg[1:0], port_mode_select_line};
            a0_sync_reg <= {a0_sync_reg[1:0], register_select_line};
        end
    end

    // Filtered levels change only when stages two and three agree
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cs_reg <= 1'b1;
            rd_reg <= 1'b1;
            wr_reg <= 1'b1;
            a1_reg <= 1'b0;
            a0_reg <= 1'b0;
        end
        else
        begin
            if (cs_sync_reg[1] == cs_sync_reg[2]) cs_reg <= cs_sync_reg[2];
            if (rd_sync_reg[1] == rd_sync_reg[2]) rd_reg <= rd_sync_reg[2];
            if (wr_sync_reg[1] == wr_sync_reg[2]) wr_reg <= wr_sync_reg[2];
            if (a1_sync_reg[1] == a1_sync_reg[2]) a1_reg <= a1_sync_reg[2];
            if (a0_sync_reg[1] == a0_sync_reg[2]) a0_reg <= a0_sync_reg[2];
        end
    end

    // Strobe edges qualified by chip select only; mode decoded separately
    assign rd_rise = !rd_reg && (rd_sync_reg[1] == rd_sync_reg[2]) && rd_sync_reg[2] && !cs_reg;
    assign wr_rise = !wr_reg && (wr_sync_reg[1] == wr_sync_reg[2]) && wr_sync_reg[2] && !cs_reg;
    assign sel_mbox = !a1_reg;
    assign sel_fast = a1_reg;

    // Status byte layout
    always_comb
    begin
        status_byte = '0;
        status_byte[HPP_STAT_VACANT_BIT] = !host_attention_out;
        status_byte[HPP_STAT_FULL_BIT] = inbound_full_reg;
        status_byte[HPP_STAT_FULL_BIT-1 -: 2] = HPP_UNUSED_BITS;
        status_byte[HPP_TAG_W-1:0] = stream_tag;
    end

    // Outbound mailbox: firmware loads, host data read empties at strobe rise
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            host_attention_out <= 1'b0;
            out_byte_reg <= '0;
        end
        else if (outbound_load)
        begin
            host_attention_out <= 1'b1; // Load wins over a simultaneous read
            out_byte_reg <= outbound_byte;
        end
        else if (rd_rise && sel_mbox && !a0_reg)
            host_attention_out <= 1'b0;
    end

    // Inbound mailbox: host byte held until the CPU takes it
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            inbound_valid <= 1'b0;
            inbound_byte <= '0;
            inbound_is_control <= 1'b0;
        end
        else if (wr_rise && sel_mbox && !inbound_full_reg)
        begin
            inbound_valid <= 1'b1;
            inbound_byte <= host_data_bus_in[HPP_MBOX_W-1:0];
            inbound_is_control <= a0_reg;
        end
        else if (cpu_take)
            inbound_valid <= 1'b0;
    end

    // Inbound full while a byte waits or the CPU FIFO is full
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            inbound_full_reg <= 1'b1;
        else
            inbound_full_reg <= cpu_fifo_full_bit || (inbound_valid && !cpu_take) ||
                (wr_rise && sel_mbox);
    end

    // Fast mode: internal bus transaction per strobe
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fast_state_reg <= HPP_FAST_IDLE;
            abus_req <= 1'b0;
            abus_write <= 1'b0;
            abus_addr <= '0;
            abus_wdata <= '0;
            read_word_reg <= '0;
            fast_pending_reg <= 1'b0;
            fast_is_write_reg <= 1'b0;
        end
        else
        begin
            case (fast_state_reg)
                HPP_FAST_IDLE:
                begin
                    if (sel_fast && (rd_rise || wr_rise))
                    begin
                        fast_state_reg <= HPP_FAST_BUSY;
                        abus_req <= 1'b1;
                        abus_write <= wr_rise;
                        abus_wdata <= wide_bus_enable ? wdata_reg :
                            {{(HPP_FAST_W-HPP_MBOX_W){1'b0}}, wdata_reg[HPP_MBOX_W-1:0]};
                        if (!burst_enable || !fast_pending_reg)
                            abus_addr <= burst_base_addr;
                        fast_pending_reg <= 1'b1;
                        fast_is_write_reg <= wr_rise;
                    end
                end
                HPP_FAST_BUSY:
                begin
                    if (abus_ack)
                    begin
                        abus_req <= 1'b0;
                        fast_state_reg <= HPP_FAST_HOLD;
                        if (!fast_is_write_reg)
                            read_word_reg <= abus_rdata;
                        if (burst_enable)
                            abus_addr <= abus_addr + ADDR_W'(1);
                    end
                end
                HPP_FAST_HOLD:
                    fast_state_reg <= HPP_FAST_IDLE;
                default:
                    fast_state_reg <= HPP_FAST_IDLE;
            endcase
            if (!burst_enable)
                fast_pending_reg <= 1'b0;
        end
    end

    // Capture write data while write strobe is low
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            wdata_reg <= '0;
        else if (!wr_reg)
            wdata_reg <= host_data_bus_in;
    end

    // Ready low from strobe rise until internal transfer and minimum width are done
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            transfer_ready_out <= 1'b1;
            ready_cnt_reg <= '0;
        end
        else if (fast_state_reg == HPP_FAST_IDLE && sel_fast && (rd_rise || wr_rise))
        begin
            transfer_ready_out <= 1'b0;
            ready_cnt_reg <= 8'(HPP_RDY_LOW_CYC - 1);
        end
        else if (ready_cnt_reg != 8'h00)
            ready_cnt_reg <= ready_cnt_reg - 8'h01;
        else if (fast_state_reg == HPP_FAST_IDLE)
            transfer_ready_out <= 1'b1;
    end

    // Read data driver: bus enabled while selected read strobe is low
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            host_data_bus_oe_n <= 1'b1;
            host_data_bus_out <= '0;
        end
        else
        begin
            host_data_bus_oe_n <= !(!rd_reg && !cs_reg) || rd_rise;
            if (sel_fast)
                host_data_bus_out <= wide_bus_enable ? read_word_reg :
                    {{(HPP_FAST_W-HPP_MBOX_W){1'b0}}, read_word_reg[HPP_MBOX_W-1:0]};
            else if (a0_reg)
                host_data_bus_out <= {{(HPP_FAST_W-HPP_MBOX_W){1'b0}}, status_byte};
            else
                host_data_bus_out <= {{(HPP_FAST_W-HPP_MBOX_W){1'b0}}, out_byte_reg};
        end
    end
endmodule // hpp_host_port

// File: rtl/hpp_pkg.sv
/*
 Constants for the host parallel slave port: status byte layout,
 bus widths, fast-mode ready timing and internal bus handshake states.
 Assumes a single 250 MHz system clock.
*/
package hpp_pkg;
    localparam int HPP_CLK_PERIOD_PS = 4000;
    localparam int HPP_RDY_LOW_MIN_NS = 15;
    localparam int HPP_RDY_LOW_CYC = (HPP_RDY_LOW_MIN_NS * 1000 + HPP_CLK_PERIOD_PS - 1) / HPP_CLK_PERIOD_PS;
    localparam int HPP_STAT_VACANT_BIT = 7;
    localparam int HPP_STAT_FULL_BIT = 6;
    localparam int HPP_TAG_W = 4;
    localparam int HPP_MBOX_W = 8;
    localparam int HPP_FAST_W = 16;
    localparam int HPP_SYNC_W = 3;
    localparam logic [1:0] HPP_UNUSED_BITS = 2'h0;
    typedef enum logic [1:0]
    {
        HPP_FAST_IDLE = 2'b00,
        HPP_FAST_BUSY = 2'b01,
        HPP_FAST_HOLD = 2'b10
    } hpp_fast_state_t;
endpackage

// File: tb/host_parallel_slave_port_tb_top.sv
/* Self-checking bench for the host port: mailbox and fast modes.
   Host and firmware sides driven here; hpp_abus_target answers the internal bus. */
module host_parallel_slave_port_tb_top
    import hpp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, sys_rst = 1'b1, host_select_n = 1'b1, port_mode_select_line = 1'b0;
    logic register_select_line = 1'b0, host_read_strobe_n = 1'b1, host_write_strobe_n = 1'b1, cpu_take = 1'b0;
    logic wide_bus_enable = 1'b0, burst_enable = 1'b0, outbound_load = 1'b0, cpu_fifo_full_bit = 1'b0;
    logic [15:0] host_data_bus_in = 16'h0000, host_data_bus_out, abus_wdata, abus_rdata, rd;
    logic [15:0] wv [0:3];
    logic [23:0] burst_base_addr = 24'h000000, abus_addr;
    logic [3:0] stream_tag = 4'h0, dly = 4'h0;
    logic [7:0] outbound_byte = 8'h00, inbound_byte;
    logic host_data_bus_oe_n, host_attention_out, transfer_ready_out, inbound_valid, inbound_is_control;
    logic abus_req, abus_write, abus_ack;
    int bad_count = 0, compares = 0;
    always #2 clk = ~clk;
    hpp_host_port #(.ADDR_W(24)) dut_u (.clk, .sys_rst, .host_select_n, .port_mode_select_line,
        .register_select_line, .host_read_strobe_n, .host_write_strobe_n, .host_data_bus_in, .host_data_bus_out,
        .host_data_bus_oe_n, .host_attention_out, .transfer_ready_out, .wide_bus_enable, .burst_enable,
        .burst_base_addr, .stream_tag, .outbound_load, .outbound_byte, .cpu_fifo_full_bit, .cpu_take,
        .inbound_valid, .inbound_byte, .inbound_is_control, .abus_req, .abus_write, .abus_addr, .abus_wdata,
        .abus_ack, .abus_rdata);
    hpp_abus_target #(.ADDR_W(24)) tgt_u (.clk, .abus_req, .abus_write, .abus_addr, .abus_wdata,
        .delay(dly), .abus_ack, .abus_rdata);
    // Expected status byte from vacant and full flags
    function automatic logic [15:0] stat(input logic v, input logic f);
        return {8'h00, v, f, 2'b00, stream_tag};
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // One host strobe cycle; waits for ready before returning
    task automatic hcyc(input logic m, input logic r, input logic w, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk);
        host_select_n <= 1'b0;
        port_mode_select_line <= m;
        register_select_line <= r;
        host_data_bus_in <= d;
        @(posedge clk);
        host_write_strobe_n <= !w;
        host_read_strobe_n <= w;
        repeat (7) @(posedge clk);
        q = host_data_bus_out;
        host_read_strobe_n <= 1'b1;
        host_write_strobe_n <= 1'b1;
        repeat (2) @(posedge clk);
        host_select_n <= 1'b1;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 200 && transfer_ready_out !== 1'b1; i++) @(posedge clk);
    endtask
    task automatic conclude();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(79));
        stream_tag <= 4'($urandom);
        burst_base_addr <= 24'($urandom_range(0, 11));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        chk("ready", 16'h0001, {15'h0, transfer_ready_out});
        hcyc(0, 1, 0, 16'h0000, rd);
        chk("status", stat(1, 0), rd);
        outbound_byte <= 8'($urandom);
        outbound_load <= 1'b1;
        @(posedge clk);
        outbound_load <= 1'b0;
        @(posedge clk);
        chk("attention", 16'h0001, {15'h0, host_attention_out});
        hcyc(0, 1, 0, 16'h0000, rd);
        chk("status", stat(0, 0), rd);
        hcyc(0, 0, 0, 16'h0000, rd);
        chk("data", {8'h00, outbound_byte}, rd);
        chk("attention", 16'h0000, {15'h0, host_attention_out});
        chk("bus released", 16'h0001, {15'h0, host_data_bus_oe_n});
        wv[0] = 16'($urandom);
        hcyc(0, 0, 1, wv[0], rd);
        chk("inbound", {6'h00, 2'b01, wv[0][7:0]}, {6'h00, inbound_is_control, inbound_valid, inbound_byte});
        cpu_fifo_full_bit <= 1'b1;
        hcyc(0, 0, 1, ~wv[0], rd);
        chk("refused", {8'h00, wv[0][7:0]}, {8'h00, inbound_byte});
        cpu_take <= 1'b1;
        @(posedge clk);
        cpu_take <= 1'b0;
        hcyc(0, 1, 0, 16'h0000, rd);
        chk("status", stat(1, 1), rd);
        cpu_fifo_full_bit <= 1'b0;
        hcyc(0, 1, 0, 16'h0000, rd);
        chk("status", stat(1, 0), rd);
        hcyc(0, 1, 1, wv[0], rd);
        chk("control", {6'h00, 2'b11, wv[0][7:0]}, {6'h00, inbound_is_control, inbound_valid, inbound_byte});
        wide_bus_enable <= 1'b1;
        burst_enable <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            wv[i] = 16'($urandom);
            dly <= 4'($urandom_range(0, 7));
            hcyc(1, 1'($urandom), 1, wv[i], rd);
        end
        burst_enable <= 1'b0;
        repeat (4) @(posedge clk);
        burst_enable <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            wide_bus_enable <= (i != 4);
            dly <= 4'($urandom_range(0, 7));
            hcyc(1, 1'($urandom), 0, 16'h0000, rd);
            if (i > 0)
                chk("fast read", (i == 4) ? {8'h00, wv[3][7:0]} : wv[i-1], rd);
        end
        // Single access: every strobe goes back to the base address
        burst_enable <= 1'b0;
        wide_bus_enable <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            dly <= 4'($urandom_range(0, 7));
            hcyc(1, 1'($urandom), 0, 16'h0000, rd);
            if (i > 0)
                chk("single read", wv[0], rd);
        end
        conclude();
    end
    // Watchdog: the run needs a few hundred cycles, allow 10000 cycles
    initial
    begin
        #40000;
        bad_count++;
        conclude();
    end
endmodule // host_parallel_slave_port_tb_top

// File: tb/hpp_abus_target.sv
/* Behavioural internal bus target: a small word store.
   Assumes the request stays up until acknowledge; delay is set by the bench. */
module hpp_abus_target
    import hpp_pkg::*;
#(parameter int ADDR_W = 24)
(
    input wire logic clk,
    input wire logic abus_req,
    input wire logic abus_write,
    input wire logic [ADDR_W-1:0] abus_addr,
    input wire logic [HPP_FAST_W-1:0] abus_wdata,
    input wire logic [3:0] delay,
    output logic abus_ack,
    output logic [HPP_FAST_W-1:0] abus_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [HPP_FAST_W-1:0] mem [0:15];
    // Answer after the set delay, then scramble the data lines
    initial
    begin
        abus_ack = 1'b0;
        abus_rdata = 16'h0000;
        forever
        begin
            @(posedge clk);
            if (abus_req)
            begin
                repeat (delay) @(posedge clk);
                abus_ack <= 1'b1;
                abus_rdata <= mem[abus_addr[3:0]];
                if (abus_write)
                    mem[abus_addr[3:0]] <= abus_wdata;
                @(posedge clk);
                abus_ack <= 1'b0;
                abus_rdata <= ~mem[abus_addr[3:0]];
                @(posedge clk);
            end
        end
    end
endmodule // hpp_abus_target

// File: tb/hpp_host_port_asserts.sv
/* Concurrent checks on the host port outputs and internal bus handshake.
   Assumes binding into hpp_host_port on its single clock. */
module hpp_host_port_asserts
    import hpp_pkg::*;
#(parameter int ADDR_W = 24)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic host_select_n,
    input wire logic port_mode_select_line,
    input wire logic host_read_strobe_n,
    input wire logic [HPP_FAST_W-1:0] host_data_bus_out,
    input wire logic host_data_bus_oe_n,
    input wire logic host_attention_out,
    input wire logic transfer_ready_out,
    input wire logic wide_bus_enable,
    input wire logic outbound_load,
    input wire logic cpu_take,
    input wire logic inbound_valid,
    input wire logic abus_req,
    input wire logic abus_write,
    input wire logic [ADDR_W-1:0] abus_addr,
    input wire logic abus_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Ready pulse, bus request and mailbox relations
    property p_rdy_low; $fell(transfer_ready_out) |-> !transfer_ready_out [*4]; endproperty
    a_rdy_low: assert property (p_rdy_low) else $error("ready low pulse too short");
    property p_req_busy; abus_req |-> !transfer_ready_out; endproperty
    a_req_busy: assert property (p_req_busy) else $error("ready high during transfer");
    property p_req_hold; abus_req && !abus_ack |=> abus_req && $stable(abus_addr) && $stable(abus_write); endproperty
    a_req_hold: assert property (p_req_hold) else $error("bus request dropped early");
    property p_load_attn; outbound_load |=> host_attention_out; endproperty
    a_load_attn: assert property (p_load_attn) else $error("attention missing");
    property p_attn_drop; $fell(host_attention_out) |-> $past(host_read_strobe_n, 2); endproperty
    a_attn_drop: assert property (p_attn_drop) else $error("attention fell early");
    property p_in_hold; inbound_valid && !cpu_take |=> inbound_valid; endproperty
    a_in_hold: assert property (p_in_hold) else $error("inbound byte lost");
    property p_narrow; !wide_bus_enable && !host_data_bus_oe_n |-> host_data_bus_out[15:8] == 8'h00; endproperty
    a_narrow: assert property (p_narrow) else $error("upper byte driven");
    property p_mbox; !port_mode_select_line && !$past(port_mode_select_line, 8) && !host_data_bus_oe_n
        |-> host_data_bus_out[15:8] == 8'h00; endproperty
    a_mbox: assert property (p_mbox) else $error("mailbox upper byte");
    property p_oe; $fell(host_data_bus_oe_n) |-> !$past(host_read_strobe_n, 3) && !$past(host_select_n, 3); endproperty
    a_oe: assert property (p_oe) else $error("bus driven without read");
    c_fwr: cover property ($fell(transfer_ready_out) && abus_write);
    c_attn: cover property ($fell(host_attention_out));
    c_in: cover property ($rose(inbound_valid));
endmodule // hpp_host_port_asserts
bind hpp_host_port hpp_host_port_asserts #(.ADDR_W(ADDR_W)) chk_u (.clk, .sys_rst, .host_select_n,
    .port_mode_select_line, .host_read_strobe_n, .host_data_bus_out, .host_data_bus_oe_n, .host_attention_out,
    .transfer_ready_out, .wide_bus_enable, .outbound_load, .cpu_take, .inbound_valid, .abus_req, .abus_write,
    .abus_addr, .abus_ack);
